// File: core/event_detector_regs.svh
// Contract
// - enabled A rise: one-cycle output pulse on each A rising edge, B ignored.
// - enabled A fall: one-cycle output pulse on each A falling edge, B ignored.
// - enabled A low: output high while A stays low, B ignored.
// - enabled A high: output high while A stays high, B ignored.
// - enabled B fall: one-cycle output pulse on each B falling edge, A ignored.
// - enabled B low: output high throughout every B low interval, A ignored.
// - enabled B high: output high throughout every B high interval, A ignored.
// - enabled: one-cycle pulse when A rises while B is low.
// - enabled: one-cycle pulse when A rises while B is high.
// - enabled: one-cycle pulse when A falls while B is low.
// - enabled: one-cycle pulse when A falls while B is high.
// - enabled: one-cycle pulse when B rises while A is low.
// - enabled: one-cycle pulse when B rises while A is high.
// - enabled: one-cycle pulse when B falls while A is low.
// - enabled: one-cycle pulse when B falls while A is high.
`ifndef EVENT_DETECTOR_REGS_SVH
`define EVENT_DETECTOR_REGS_SVH

// ***************************************
// register offsets
// ***************************************
`define EVD_ADDR_W 8
`define EVD_OFS_COND_EN 8'h00
`define EVD_OFS_STATUS 8'h04
`define EVD_OFS_LAST_HIT 8'h08
`define EVD_OFS_EVT_COUNT 8'h0C

// ***************************************
// reset values
// ***************************************
`define EVD_COND_EN_RST 16'h0000
`define EVD_COUNT_RST 16'h0000

// ***************************************
// condition enable bit positions
// ***************************************
`define EVD_A_RISE 0
`define EVD_A_FALL 1
`define EVD_A_LOW 2
`define EVD_A_HIGH 3
`define EVD_B_RISE 4
`define EVD_B_FALL 5
`define EVD_B_LOW 6
`define EVD_B_HIGH 7
`define EVD_AR_BL 8
`define EVD_AR_BH 9
`define EVD_AF_BL 10
`define EVD_AF_BH 11
`define EVD_AL_BR 12
`define EVD_AH_BR 13
`define EVD_AL_BF 14
`define EVD_AH_BF 15

// ***************************************
// status bit positions
// ***************************************
`define EVD_ST_A_LVL 0
`define EVD_ST_B_LVL 1
`define EVD_ST_EVENT 2
`define EVD_ST_SEEN 3

`endif

// File: core/event_detector_pkg.sv
package event_detector_pkg;

	typedef logic [15:0] cond_vec_t;
	typedef logic [31:0] word_t;

	typedef enum logic [2:0] {
		SEL_NONE = 3'b000,
		SEL_COND_EN = 3'b001,
		SEL_STATUS = 3'b010,
		SEL_LAST_HIT = 3'b011,
		SEL_EVT_COUNT = 3'b100
	} reg_sel_e;

endpackage : event_detector_pkg

// File: core/input_sampler.sv
`timescale 1ns/100ps
module input_sampler
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic ce,
	// raw phase inputs
	input wire logic phase_a,
	input wire logic phase_b,
	// current and previous samples
	output logic a_cur,
	output logic a_prev,
	output logic b_cur,
	output logic b_prev
);

	// inputs are synchronous, so one stage gives the current level
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			a_cur <= 1'b0;
			b_cur <= 1'b0;
		end
		else if (ce)
		begin
			a_cur <= phase_a;
			b_cur <= phase_b;
		end
	end

	// previous sample; equal to current after reset, so no false edge
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			a_prev <= 1'b0;
			b_prev <= 1'b0;
		end
		else if (ce)
		begin
			a_prev <= a_cur;
			b_prev <= b_cur;
		end
	end

endmodule : input_sampler

// File: core/cond_matcher.sv
`timescale 1ns/100ps
`include "event_detector_regs.svh"
module cond_matcher
	import event_detector_pkg::*;
(
	// samples
	input wire logic a_cur,
	input wire logic a_prev,
	input wire logic b_cur,
	input wire logic b_prev,
	// enables
	input wire cond_vec_t cond_en,
	// per-condition hits, already masked
	output cond_vec_t hit
);

	// ***************************************
	// raw condition evaluation
	// ***************************************
	function automatic cond_vec_t eval_conds(input logic ac, input logic ap, input logic bc, input logic bp);
		logic ar;
		logic af;
		logic br;
		logic bf;
		cond_vec_t v;
		ar = ac & ~ap;
		af = ~ac & ap;
		br = bc & ~bp;
		bf = ~bc & bp;
		v = 16'h0000;
		v[`EVD_A_RISE] = ar;
		v[`EVD_A_FALL] = af;
		v[`EVD_A_LOW] = ~ac;
		v[`EVD_A_HIGH] = ac;
		v[`EVD_B_RISE] = br;
		v[`EVD_B_FALL] = bf;
		v[`EVD_B_LOW] = ~bc;
		v[`EVD_B_HIGH] = bc;
		v[`EVD_AR_BL] = ar & ~bc;
		v[`EVD_AR_BH] = ar & bc;
		v[`EVD_AF_BL] = af & ~bc;
		v[`EVD_AF_BH] = af & bc;
		v[`EVD_AL_BR] = br & ~ac;
		v[`EVD_AH_BR] = br & ac;
		v[`EVD_AL_BF] = bf & ~ac;
		v[`EVD_AH_BF] = bf & ac;
		return v;
	endfunction : eval_conds

	// qualifier taken at the edge's own sample, so both inputs moving together still match
	assign hit = eval_conds(a_cur, a_prev, b_cur, b_prev) & cond_en;

endmodule : cond_matcher

// File: core/two_input_event_detector.sv
`timescale 1ns/100ps
`include "event_detector_regs.svh"
module two_input_event_detector
	import event_detector_pkg::*;
(
	// clock, reset, enable
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic ce,
	// phase inputs
	input wire logic phase_a,
	input wire logic phase_b,
	// register port
	input wire logic [`EVD_ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// detected event to counter-timer
	output logic event_out
);

	// ***************************************
	// declarations
	// ***************************************
	logic a_cur;
	logic a_prev;
	logic b_cur;
	logic b_prev;
	cond_vec_t hit;
	cond_vec_t cond_en_r;
	cond_vec_t last_hit_r;
	logic [15:0] evt_count_r;
	logic [15:0] evt_count_nxt;
	logic seen_r;
	logic event_r;
	logic any_hit;
	word_t rdata_r;
	word_t rdata_nxt;
	reg_sel_e wr_sel;
	reg_sel_e rd_sel;

	// ***************************************
	// address decode
	// ***************************************
	// unmapped offsets select nothing: writes dropped, reads zero
	function automatic reg_sel_e decode(input logic [`EVD_ADDR_W-1:0] a);
		reg_sel_e s;
		if (a == `EVD_OFS_COND_EN)
			s = SEL_COND_EN;
		else if (a == `EVD_OFS_STATUS)
			s = SEL_STATUS;
		else if (a == `EVD_OFS_LAST_HIT)
			s = SEL_LAST_HIT;
		else if (a == `EVD_OFS_EVT_COUNT)
			s = SEL_EVT_COUNT;
		else
			s = SEL_NONE;
		return s;
	endfunction : decode

	assign wr_sel = reg_wr ? decode(reg_addr) : SEL_NONE;
	assign rd_sel = reg_rd ? decode(reg_addr) : SEL_NONE;

	// ***************************************
	// sampling and matching
	// ***************************************
	input_sampler u_sampler
	(
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.ce(ce),
		.phase_a(phase_a),
		.phase_b(phase_b),
		.a_cur(a_cur),
		.a_prev(a_prev),
		.b_cur(b_cur),
		.b_prev(b_prev)
	);

	cond_matcher u_matcher
	(
		.a_cur(a_cur),
		.a_prev(a_prev),
		.b_cur(b_cur),
		.b_prev(b_prev),
		.cond_en(cond_en_r),
		.hit(hit)
	);

	assign any_hit = |hit;

	// ***************************************
	// condition enables
	// ***************************************
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			cond_en_r <= `EVD_COND_EN_RST;
		else if (ce && wr_sel == SEL_COND_EN)
			cond_en_r <= reg_wdata[15:0];
	end

	// ***************************************
	// event output
	// ***************************************
	// registered so the counter-timer sees a clean pulse or level, one cycle after the hit
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			event_r <= 1'b0;
		else if (ce)
			event_r <= any_hit;
	end

	assign event_out = event_r;

	// ***************************************
	// diagnostics
	// ***************************************
	// last hit pattern kept until the next hit
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			last_hit_r <= 16'h0000;
		else if (ce && any_hit)
			last_hit_r <= hit;
	end

	// sticky seen flag; a new hit wins over a software clear
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			seen_r <= 1'b0;
		else if (ce)
		begin
			if (any_hit)
				seen_r <= 1'b1;
			else if (wr_sel == SEL_STATUS && reg_wdata[`EVD_ST_SEEN])
				seen_r <= 1'b0;
		end
	end

	// counts cycles with any hit, updated on the same edge as the output; saturates rather than wraps
	always_comb
	begin
		evt_count_nxt = evt_count_r;
		if (wr_sel == SEL_EVT_COUNT)
			evt_count_nxt = {15'h0000, any_hit};
		else if (any_hit && evt_count_r != 16'hFFFF)
			evt_count_nxt = evt_count_r + 16'h0001;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			evt_count_r <= `EVD_COUNT_RST;
		else if (ce)
			evt_count_r <= evt_count_nxt;
	end

	// ***************************************
	// read path
	// ***************************************
	always_comb
	begin
		rdata_nxt = 32'h0000_0000;
		case (rd_sel)
			SEL_COND_EN: rdata_nxt = {16'h0000, cond_en_r};
			SEL_STATUS:
			begin
				rdata_nxt[`EVD_ST_A_LVL] = a_cur;
				rdata_nxt[`EVD_ST_B_LVL] = b_cur;
				rdata_nxt[`EVD_ST_EVENT] = event_r;
				rdata_nxt[`EVD_ST_SEEN] = seen_r;
			end
			SEL_LAST_HIT: rdata_nxt = {16'h0000, last_hit_r};
			SEL_EVT_COUNT: rdata_nxt = {16'h0000, evt_count_r};
			default: rdata_nxt = 32'h0000_0000;
		endcase
	end

	// data valid only in the cycle after the read strobe
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			rdata_r <= 32'h0000_0000;
		else if (ce)
			rdata_r <= rdata_nxt;
	end

	assign reg_rdata = rdata_r;

endmodule : two_input_event_detector

// File: dv/event_counter_model.sv
`timescale 1ns/100ps
module event_counter_model
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// gate and event
	input wire logic gate,
	input wire logic event_out,
	// running total
	output logic [31:0] count
);
	// ****
	// counts high cycles, so a level adds one per cycle
	// ****
	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
			count <= 32'h0;
		else if (gate && event_out)
			count <= count + 32'h1;
endmodule : event_counter_model

// File: dv/two_input_event_detector_assertions.sv
`timescale 1ns/100ps
`include "event_detector_regs.svh"
module event_detector_checker
	import event_detector_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic ce,
	// inputs
	input wire logic phase_a,
	input wire logic phase_b,
	input wire logic [`EVD_ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	// output
	input wire logic event_out
);
	// ****
	// shadow of enables and samples
	// ****
	cond_vec_t en_r;
	cond_vec_t hit;
	logic [3:0] smp_r;
	logic ac, bc, ar, af, br, bf;
	logic hit_any;
	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
			en_r <= 16'h0;
		else if (ce && reg_wr && reg_addr == `EVD_OFS_COND_EN)
			en_r <= reg_wdata[15:0];
	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
			smp_r <= 4'h0;
		else if (ce)
			smp_r <= {phase_a, smp_r[3], phase_b, smp_r[1]};
	assign ac = smp_r[3];
	assign bc = smp_r[1];
	assign ar = ac & !smp_r[2];
	assign af = !ac & smp_r[2];
	assign br = bc & !smp_r[0];
	assign bf = !bc & smp_r[0];
	assign hit = en_r & {bf & ac, bf & !ac, br & ac, br & !ac, af & bc, af & !bc, ar & bc, ar & !bc,
		bc, !bc, bf, br, ac, !ac, af, ar};
	assign hit_any = |hit;
	// ****
	// properties; a frozen cycle (ce low) skips checking
	// ****
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n || !ce);
	a_rise_a:
		assert property (hit[0] |=> event_out) else $error("a rise missed");
	a_fall_a:
		assert property (hit[1] |=> event_out) else $error("a fall missed");
	a_low_a:
		assert property (hit[2] |=> event_out) else $error("a low missed");
	a_high_a:
		assert property (hit[3] |=> event_out) else $error("a high missed");
	b_fall_a:
		assert property (hit[5] |=> event_out) else $error("b fall missed");
	b_low_a:
		assert property (hit[6] |=> event_out) else $error("b low missed");
	b_high_a:
		assert property (hit[7] |=> event_out) else $error("b high missed");
	cross_edge_a:
		assert property (|hit[15:8] |=> event_out) else $error("qualified edge missed");
	event_or_a:
		assert property (1'b1 |=> event_out == $past(hit_any)) else $error("event not or of hits");
	quiet_off_a:
		assert property (en_r == 16'h0 |=> !event_out) else $error("event while disabled");
endmodule : event_detector_checker

bind two_input_event_detector event_detector_checker u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce),
	.phase_a(phase_a), .phase_b(phase_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.event_out(event_out));

// File: dv/two_input_event_detector_tb_top.sv
`timescale 1ns/100ps
`include "event_detector_regs.svh"
module two_input_event_detector_tb_top import event_detector_pkg::*;;
	logic sys_clk, rst_n, ce, phase_a, phase_b, reg_wr, reg_rd, gate, event_out;
	logic [`EVD_ADDR_W-1:0] reg_addr;
	word_t reg_wdata, reg_rdata, count, rd_val;
	int err_count, n_compared;
	// ****
	// high cycles per single enable over one sweep
	// ****
	word_t exp_cnt [16] = '{2, 2, 10, 8, 2, 2, 10, 8, 1, 1, 1, 1, 1, 1, 1, 1};
	logic [1:0] sweep [9] = '{2'b10, 2'b11, 2'b01, 2'b00, 2'b01, 2'b11, 2'b10, 2'b00, 2'b00};
	two_input_event_detector dut (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .phase_a(phase_a),
		.phase_b(phase_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .event_out(event_out));
	event_counter_model model (.sys_clk(sys_clk), .rst_n(rst_n), .gate(gate), .event_out(event_out),
		.count(count));
	initial
	begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	// ****
	// tasks
	// ****
	task automatic check(input word_t got, input word_t exp);
		n_compared++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input word_t d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output word_t d);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		d = reg_rdata;
	endtask : rd
	// inputs rest at 00 before each sweep; output lags input by two edges
	task automatic sweep_run(input word_t en, input word_t exp);
		word_t n0;
		wr(`EVD_OFS_COND_EN, en);
		repeat (3) @(posedge sys_clk);
		n0 = count;
		for (int j = 0; j < 18; j++)
		begin
			@(posedge sys_clk);
			{phase_a, phase_b} <= sweep[j / 2];
			gate <= 1'b1;
		end
		@(posedge sys_clk);
		gate <= 1'b0;
		@(posedge sys_clk);
		check(count - n0, exp);
	endtask : sweep_run
	task automatic close_out;
		if (err_count == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : close_out
	// ****
	// tests
	// ****
	initial
	begin
		rst_n = 1'b0;
		ce = 1'b1;
		{phase_a, phase_b, reg_wr, reg_rd, gate} = 5'h0;
		reg_addr = 8'h0;
		reg_wdata = 32'h0;
		err_count = 0;
		n_compared = 0;
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		rd(`EVD_OFS_COND_EN, rd_val);
		check(rd_val, 32'h0);
		sweep_run(32'h0, 32'h0);
		for (int i = 0; i < 16; i++)
			sweep_run(32'h1 << i, exp_cnt[i]);
		sweep_run(32'h81, 32'h9);
		wr(8'h10, 32'hFFFF);
		rd(`EVD_OFS_COND_EN, rd_val);
		check(rd_val, 32'h81);
		rd(8'h10, rd_val);
		check(rd_val, 32'h0);
		rd(`EVD_OFS_LAST_HIT, rd_val);
		check(rd_val, 32'h80);
		rd(`EVD_OFS_STATUS, rd_val);
		check(rd_val, 32'h8);
		wr(`EVD_OFS_STATUS, 32'h8);
		rd(`EVD_OFS_STATUS, rd_val);
		check(rd_val, 32'h0);
		// both inputs high: levels, b-high event and sticky flag all show
		@(posedge sys_clk);
		{phase_a, phase_b} <= 2'b11;
		repeat (3) @(posedge sys_clk);
		rd(`EVD_OFS_STATUS, rd_val);
		check(rd_val, 32'hF);
		@(negedge sys_clk);
		check(reg_rdata, 32'h0);
		@(posedge sys_clk);
		{phase_a, phase_b} <= 2'b00;
		repeat (2) @(posedge sys_clk);
		wr(`EVD_OFS_EVT_COUNT, 32'h0);
		sweep_run(32'h81, 32'h9);
		rd(`EVD_OFS_EVT_COUNT, rd_val);
		check(rd_val, 32'h9);
		// write while frozen must not land
		@(posedge sys_clk);
		ce <= 1'b0;
		wr(`EVD_OFS_COND_EN, 32'h0);
		ce <= 1'b1;
		rd(`EVD_OFS_COND_EN, rd_val);
		check(rd_val, 32'h81);
		close_out();
	end
	// a sweep needs under 30 cycles
	initial
	begin
		repeat (3000) @(posedge sys_clk);
		err_count++;
		close_out();
	end
endmodule : two_input_event_detector_tb_top
